// File: bench/adc_control_regs_bench.sv
`timescale 1ns/1ns
module adc_control_regs_bench;
    import adc_control_pkg::*;
    // =====================================================================
    // hookup
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clockEnable = 1'b1;
    logic [7:0] address = 8'h00;
    logic [7:0] writeData = 8'h00;
    logic writeStrobe = 1'b0;
    logic readStrobe = 1'b0;
    logic [7:0] readData;
    logic comparatorHigh;
    analogCtrl_t analogCtrl;
    logic irq;
    logic [11:0] inputLevel = 12'hA5B;
    int n_fail = 0;
    int samples_checked = 0;
    int sampleCycles = 0;
    int divs[4] = '{16, 8, 1, 2};
    int widths[4] = '{1, 2, 4, 8};

    always #25 clock = ~clock;
    always @(posedge clock) if (analogCtrl.sampling === 1'b1) sampleCycles++;

    adc_control_regs adc_control_regs_i (.clock(clock), .rst(rst), .clockEnable(clockEnable),
        .address(address), .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
        .readData(readData), .comparatorHigh(comparatorHigh), .analogCtrl(analogCtrl), .irq(irq));
    analog_core_model analog_core_model_i (.clock(clock), .inputLevel(inputLevel),
        .analogCtrl(analogCtrl), .comparatorHigh(comparatorHigh));

    // =====================================================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        // data stands only in the cycle after the strobe
        @(negedge clock);
        d = readData;
    endtask : rdr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rdr(a, d);
        check(d, exp);
    endtask : rdchk

    // =====================================================================
    // scenarios
    task automatic t_reset();
        rdchk(MODE_CONTROL_ADDR, 8'h20);
        rdchk(CLOCK_FLAG_ADDR, 8'h00);
        rdchk(RESULT_HIGH_ADDR, 8'h00);
        rdchk(REFERENCE_ADDR, 8'h03);
        rdchk(SAMPLE_RES_ADDR, 8'h0A);
        check(analogCtrl.powerUp, 1'b0);
        check(analogCtrl.referenceLevel, 2'h3);
        $display("reset values done");
    endtask : t_reset

    task automatic t_regs();
        for (int v = 0; v < 4; v++) begin
            wr(REFERENCE_ADDR, {v[0], 5'h00, v[1:0]});
            rdchk(REFERENCE_ADDR, {v[0], 5'h00, v[1:0]});
            check(analogCtrl.externalReference, v[0]);
            check(analogCtrl.referenceLevel, v[1:0]);
        end
        wr(SAMPLE_RES_ADDR, 8'hFF);
        rdchk(SAMPLE_RES_ADDR, 8'h7F);
        check(analogCtrl.portbDigitalOff, 3'h7);
        wr(SAMPLE_RES_ADDR, 8'h0A);
        check(analogCtrl.portbDigitalOff, 3'h7);
        rdchk(SAMPLE_RES_ADDR, 8'h0A);
        check(analogCtrl.portbDigitalOff, 3'h0);
        wr(RESULT_HIGH_ADDR, 8'hFF);
        rdchk(RESULT_HIGH_ADDR, 8'h00);
        wr(CLOCK_FLAG_ADDR, 8'h0F);
        rdchk(CLOCK_FLAG_ADDR, 8'h00);
        wr(8'h15, 8'hFF);
        rdchk(8'h15, 8'h00);
        // start without enable must not launch anything
        wr(MODE_CONTROL_ADDR, 8'h40);
        rdchk(MODE_CONTROL_ADDR, 8'h20);
        $display("register access done");
    endtask : t_regs

    task automatic t_channels();
        logic [12:0] exp;
        for (int g = 0; g < 2; g++) begin
            for (int c = 0; c < 16; c++) begin
                exp = (g == 1 && c < 13) ? 13'h1 << c : 13'h0;
                wr(MODE_CONTROL_ADDR, {3'b000, g[0], c[3:0]});
                rdchk(MODE_CONTROL_ADDR, {3'b001, g[0], c[3:0]});
                check(analogCtrl.channelConnect, exp);
            end
        end
        $display("channel select done");
    endtask : t_channels

    task automatic waitDone(output logic [7:0] d);
        for (int n = 0; n < 500; n++) begin
            rdr(MODE_CONTROL_ADDR, d);
            if (d[5] === 1'b1) return;
        end
        n_fail++;
        $display("Error at %0t: conversion never finished", $time);
        end_of_test();
    endtask : waitDone

    task automatic t_convert();
        logic [11:0] exp;
        logic [7:0] d;
        int w;
        for (int i = 0; i < 4; i++) begin
            exp = (i == 0) ? 12'hFF0 : (i == 1) ? 12'hFFC : 12'hFFF;
            exp = exp & inputLevel;
            w = widths[i] * divs[i];
            wr(SAMPLE_RES_ADDR, {4'h0, i[1:0], i[1:0]});
            wr(CLOCK_FLAG_ADDR, {2'b00, i[1:0], 4'h0});
            sampleCycles = 0;
            wr(MODE_CONTROL_ADDR, 8'hD0);
            rdchk(MODE_CONTROL_ADDR, 8'h90);
            check(analogCtrl.powerUp, 1'b1);
            waitDone(d);
            check(d, 8'hB0);
            // pulse length is ticks times divider, exactly
            check(sampleCycles, w);
            rdchk(CLOCK_FLAG_ADDR, {2'b10, i[1:0], exp[3:0]});
            rdchk(RESULT_HIGH_ADDR, exp[11:4]);
            check(irq, 1'b0);
        end
        $display("conversions done");
    endtask : t_convert

    task automatic t_irq();
        wr(CLOCK_FLAG_ADDR, 8'h40);
        @(negedge clock);
        check(irq, 1'b1);
        rdchk(CLOCK_FLAG_ADDR, 8'hCB);
        wr(CLOCK_FLAG_ADDR, 8'h40);
        @(negedge clock);
        check(irq, 1'b1);
        wr(CLOCK_FLAG_ADDR, 8'hC0);
        @(negedge clock);
        check(irq, 1'b0);
        rdchk(CLOCK_FLAG_ADDR, 8'h4B);
        wr(CLOCK_FLAG_ADDR, 8'h00);
        $display("interrupt done");
    endtask : t_irq

    task automatic t_abort();
        wr(SAMPLE_RES_ADDR, 8'h0E);
        wr(MODE_CONTROL_ADDR, 8'hD0);
        repeat (20) @(posedge clock);
        wr(MODE_CONTROL_ADDR, 8'hD0);
        rdchk(MODE_CONTROL_ADDR, 8'h90);
        wr(MODE_CONTROL_ADDR, 8'h10);
        rdchk(MODE_CONTROL_ADDR, 8'h30);
        check(analogCtrl.powerUp, 1'b0);
        rdchk(CLOCK_FLAG_ADDR, 8'h0B);
        rdchk(RESULT_HIGH_ADDR, 8'hA5);
        $display("abort done");
    endtask : t_abort

    task automatic t_freeze();
        // a write while the clock enable is low must leave no trace
        @(posedge clock);
        clockEnable <= 1'b0;
        wr(REFERENCE_ADDR, 8'h00);
        clockEnable <= 1'b1;
        rdchk(REFERENCE_ADDR, 8'h83);
        check(analogCtrl.externalReference, 1'b1);
        $display("clock enable freeze done");
    endtask : t_freeze

    // =====================================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_channels();
        t_convert();
        t_irq();
        t_abort();
        t_freeze();
        end_of_test();
    end
endmodule : adc_control_regs_bench

// File: bench/analog_core_model.sv
`timescale 1ns/1ns
// =====================================================================
// analog core stand-in: track/hold plus comparator
module analog_core_model
    import adc_control_pkg::*;
(
    // clock
    input wire logic clock,
    // analog side
    input wire logic [11:0] inputLevel,
    input analogCtrl_t analogCtrl,
    output logic comparatorHigh
);
    logic [11:0] held = 12'h000;
    logic junk = 1'b0;

    // hold tracks only while sampling; an open switch samples ground
    always @(posedge clock) begin
        if (analogCtrl.sampling) begin
            held <= (|analogCtrl.channelConnect) ? inputLevel : 12'h000;
        end
        junk <= ~junk;
    end

    // powered down, the comparator output is noise, never a stale answer
    assign comparatorHigh = analogCtrl.powerUp ? (held >= analogCtrl.dacCode) : junk;
endmodule : analog_core_model

// File: core/adc_control_pkg.sv
package adc_control_pkg;

    // =====================================================================
    // register offsets
    localparam logic [7:0] MODE_CONTROL_ADDR = 8'h10;
    localparam logic [7:0] CLOCK_FLAG_ADDR = 8'h11;
    localparam logic [7:0] RESULT_HIGH_ADDR = 8'h12;
    localparam logic [7:0] REFERENCE_ADDR = 8'h13;
    localparam logic [7:0] SAMPLE_RES_ADDR = 8'h14;

    // =====================================================================
    // field positions
    localparam int MODE_ENABLE_BIT = 7;
    localparam int MODE_START_BIT = 6;
    localparam int CLOCK_FLAG_BIT = 7;
    localparam int CLOCK_IRQ_ENABLE_BIT = 6;
    localparam int REF_EXTERNAL_BIT = 7;

    // =====================================================================
    // values after reset
    localparam logic EOC_RESET = 1'b1;
    localparam logic [1:0] REF_LEVEL_RESET = 2'h3;
    localparam logic [1:0] SAMPLE_WIDTH_RESET = 2'h2;
    localparam logic [1:0] RESOLUTION_RESET = 2'h2;
    localparam logic [11:0] RESULT_RESET = 12'h000;

    // =====================================================================
    // counts
    localparam logic [4:0] CLOCK_DIV_CODE0 = 5'h10;
    localparam logic [4:0] CLOCK_DIV_CODE1 = 5'h08;
    localparam logic [4:0] CLOCK_DIV_CODE2 = 5'h01;
    localparam logic [4:0] CLOCK_DIV_CODE3 = 5'h02;
    localparam logic [3:0] RES_BITS_8 = 4'h8;
    localparam logic [3:0] RES_BITS_10 = 4'hA;
    localparam logic [3:0] RES_BITS_12 = 4'hC;
    localparam logic [3:0] RESULT_MSB = 4'hB;
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;
    localparam int CHANNEL_COUNT = 13;

    // =====================================================================
    // types
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT} seqState_t;

    typedef struct packed {
        logic powerUp;
        logic sampling;
        logic [CHANNEL_COUNT-1:0] channelConnect;
        logic [11:0] dacCode;
        logic externalReference;
        logic [1:0] referenceLevel;
        logic [2:0] portbDigitalOff;
    } analogCtrl_t;

endpackage : adc_control_pkg

// File: core/adc_control_regs.sv
`timescale 1ns/1ns
// How it works
// - converter runs only while enable set
// - writing start one with enable one, while idle, launches one conversion
// - start bit always reads back zero
// - done status low while converting, high after
// - global select zero disconnects every input
// - channel code picks one of 13 pads; codes 13 to 15 connect none
// - completion sets flag; only firmware clears
// - interrupt forwarded only while interrupt enable bit set
// - clock divider codes: 16, 8, 1, 2
// - result split: low nibble, high byte
// - reference bit chooses external pin or internal
// - internal level: supply, 4V, 3V, 2V
// - sample pulse 1, 2, 4, 8 divided clock ticks
// - resolution select 8, 10, 12 bits
// - analog-only bits turn off digital inputs
module adc_control_regs
    import adc_control_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEnable,
    // register port
    input wire logic [7:0] address,
    input wire logic [7:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [7:0] readData,
    // analog core
    input wire logic comparatorHigh,
    output analogCtrl_t analogCtrl,
    // interrupt
    output logic irq
);

    // =====================================================================
    // register state
    logic enable, next_enable;
    logic globalSel, next_globalSel;
    logic [3:0] channelSel, next_channelSel;
    logic eoc, next_eoc;
    logic irqFlag, next_irqFlag;
    logic irqEnable, next_irqEnable;
    logic [1:0] clockDiv, next_clockDiv;
    logic [11:0] result, next_result;
    logic extRef, next_extRef;
    logic [1:0] refLevel, next_refLevel;
    logic [2:0] analogOnly, next_analogOnly;
    logic [1:0] sampleWidth, next_sampleWidth;
    logic [1:0] resolution, next_resolution;
    logic [7:0] next_readData;
    analogCtrl_t next_analogCtrl;

    // sequencer state
    seqState_t state, next_state;
    logic [4:0] divCount, next_divCount;
    logic [3:0] tickCount, next_tickCount;
    logic [3:0] bitPos, next_bitPos;
    logic [11:0] trial, next_trial;
    logic [1:0] settleCount, next_settleCount;
    logic tickPending, next_tickPending;

    // comparator synchroniser
    logic compMeta, compSync;

    logic writeMode, writeClock, writeReference, writeSample;
    logic startAccept, conversionDone, abortConversion, tick;
    logic [4:0] divisor;
    logic [3:0] sampleTicks, resBits, lastBit;
    logic [11:0] decided;
    logic [CHANNEL_COUNT-1:0] chanHit;

    // =====================================================================
    // decode
    assign writeMode = writeStrobe && address == MODE_CONTROL_ADDR;
    assign writeClock = writeStrobe && address == CLOCK_FLAG_ADDR;
    assign writeReference = writeStrobe && address == REFERENCE_ADDR;
    assign writeSample = writeStrobe && address == SAMPLE_RES_ADDR;
    // start counts only with enable written in the same word
    assign startAccept = writeMode && writeData[MODE_START_BIT] && writeData[MODE_ENABLE_BIT]
        && state == SEQ_IDLE;
    assign abortConversion = !enable && state != SEQ_IDLE;

    always_comb begin
        case (clockDiv)
            2'h0: divisor = CLOCK_DIV_CODE0;
            2'h1: divisor = CLOCK_DIV_CODE1;
            2'h2: divisor = CLOCK_DIV_CODE2;
            default: divisor = CLOCK_DIV_CODE3;
        endcase
        sampleTicks = 4'h1 << sampleWidth;
        if (resolution[1]) begin
            resBits = RES_BITS_12;
        end else if (resolution[0]) begin
            resBits = RES_BITS_10;
        end else begin
            resBits = RES_BITS_8;
        end
        lastBit = RESULT_MSB + 4'h1 - resBits;
    end

    // =====================================================================
    // synchroniser
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            compMeta <= 1'b0;
            compSync <= 1'b0;
        end else if (clockEnable) begin
            compMeta <= comparatorHigh;
            compSync <= compMeta;
        end
    end

    // =====================================================================
    // conversion sequencer
    // >= so a divider change mid-conversion cannot strand the count
    assign tick = state != SEQ_IDLE && divCount >= divisor - 5'h01;

    always_comb begin
        next_state = state;
        next_divCount = 5'h00;
        next_tickCount = tickCount;
        next_bitPos = bitPos;
        next_trial = trial;
        next_settleCount = settleCount;
        next_tickPending = tickPending;
        conversionDone = 1'b0;
        decided = trial;
        decided[bitPos] = compSync;
        if (state != SEQ_IDLE && !tick) begin
            next_divCount = divCount + 5'h01;
        end
        case (state)
            SEQ_IDLE: begin
                if (startAccept) begin
                    next_state = SEQ_SAMPLE;
                    next_tickCount = 4'h0;
                    next_trial = 12'h000;
                end
            end
            SEQ_SAMPLE: begin
                if (tick) begin
                    if (tickCount == sampleTicks - 4'h1) begin
                        next_state = SEQ_CONVERT;
                        next_bitPos = RESULT_MSB;
                        next_trial = 12'h800;
                        next_settleCount = 2'h0;
                        next_tickPending = 1'b0;
                    end else begin
                        next_tickCount = tickCount + 4'h1;
                    end
                end
            end
            SEQ_CONVERT: begin
                // comparator lags the code by the synchroniser, so each bit waits out a settle time
                if (settleCount != SETTLE_CYCLES) begin
                    next_settleCount = settleCount + 2'h1;
                end
                next_tickPending = tickPending || tick;
                if ((tickPending || tick) && settleCount == SETTLE_CYCLES) begin
                    next_settleCount = 2'h0;
                    next_tickPending = 1'b0;
                    next_trial = decided;
                    if (bitPos == lastBit) begin
                        next_state = SEQ_IDLE;
                        conversionDone = 1'b1;
                    end else begin
                        next_bitPos = bitPos - 4'h1;
                        next_trial[bitPos - 4'h1] = 1'b1;
                    end
                end
            end
            default: next_state = SEQ_IDLE;
        endcase
        if (abortConversion) begin
            next_state = SEQ_IDLE;
            conversionDone = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= SEQ_IDLE;
            divCount <= 5'h00;
            tickCount <= 4'h0;
            bitPos <= RESULT_MSB;
            trial <= 12'h000;
            settleCount <= 2'h0;
            tickPending <= 1'b0;
        end else if (clockEnable) begin
            state <= next_state;
            divCount <= next_divCount;
            tickCount <= next_tickCount;
            bitPos <= next_bitPos;
            trial <= next_trial;
            settleCount <= next_settleCount;
            tickPending <= next_tickPending;
        end
    end

    // =====================================================================
    // registers
    always_comb begin
        next_enable = enable;
        next_globalSel = globalSel;
        next_channelSel = channelSel;
        next_irqEnable = irqEnable;
        next_clockDiv = clockDiv;
        next_extRef = extRef;
        next_refLevel = refLevel;
        next_analogOnly = analogOnly;
        next_sampleWidth = sampleWidth;
        next_resolution = resolution;
        next_result = result;
        next_eoc = eoc;
        if (writeMode) begin
            next_enable = writeData[MODE_ENABLE_BIT];
            next_globalSel = writeData[4];
            next_channelSel = writeData[3:0];
        end
        if (writeClock) begin
            next_irqEnable = writeData[CLOCK_IRQ_ENABLE_BIT];
            next_clockDiv = writeData[5:4];
        end
        if (writeReference) begin
            next_extRef = writeData[REF_EXTERNAL_BIT];
            next_refLevel = writeData[1:0];
        end
        if (writeSample) begin
            next_analogOnly = writeData[6:4];
            next_sampleWidth = writeData[3:2];
            next_resolution = writeData[1:0];
        end
        if (startAccept) begin
            next_eoc = 1'b0;
        end
        if (conversionDone) begin
            next_result = decided;
            next_eoc = 1'b1;
        end
        if (abortConversion) begin
            next_eoc = 1'b1;
        end
        // a completion in the clearing cycle wins
        next_irqFlag = conversionDone || (irqFlag && !(writeClock && writeData[CLOCK_FLAG_BIT]));

        next_readData = 8'h00;
        if (readStrobe) begin
            if (address == MODE_CONTROL_ADDR) begin
                next_readData = {enable, 1'b0, eoc, globalSel, channelSel};
            end else if (address == CLOCK_FLAG_ADDR) begin
                next_readData = {irqFlag, irqEnable, clockDiv, result[3:0]};
            end else if (address == RESULT_HIGH_ADDR) begin
                next_readData = result[11:4];
            end else if (address == REFERENCE_ADDR) begin
                next_readData = {extRef, 5'h00, refLevel};
            end else if (address == SAMPLE_RES_ADDR) begin
                next_readData = {1'b0, analogOnly, sampleWidth, resolution};
            end
        end
    end

    // =====================================================================
    // analog controls
    for (genvar i = 0; i < CHANNEL_COUNT; i++) begin : g_channel
        assign chanHit[i] = globalSel && channelSel == 4'(i);
    end

    always_comb begin
        next_analogCtrl.powerUp = enable;
        next_analogCtrl.sampling = state == SEQ_SAMPLE;
        next_analogCtrl.channelConnect = chanHit;
        next_analogCtrl.dacCode = trial;
        next_analogCtrl.externalReference = extRef;
        next_analogCtrl.referenceLevel = refLevel;
        next_analogCtrl.portbDigitalOff = analogOnly;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enable <= 1'b0;
            globalSel <= 1'b0;
            channelSel <= 4'h0;
            eoc <= EOC_RESET;
            irqFlag <= 1'b0;
            irqEnable <= 1'b0;
            clockDiv <= 2'h0;
            result <= RESULT_RESET;
            extRef <= 1'b0;
            refLevel <= REF_LEVEL_RESET;
            analogOnly <= 3'h0;
            sampleWidth <= SAMPLE_WIDTH_RESET;
            resolution <= RESOLUTION_RESET;
            readData <= 8'h00;
            analogCtrl <= '0;
        end else if (clockEnable) begin
            enable <= next_enable;
            globalSel <= next_globalSel;
            channelSel <= next_channelSel;
            eoc <= next_eoc;
            irqFlag <= next_irqFlag;
            irqEnable <= next_irqEnable;
            clockDiv <= next_clockDiv;
            result <= next_result;
            extRef <= next_extRef;
            refLevel <= next_refLevel;
            analogOnly <= next_analogOnly;
            sampleWidth <= next_sampleWidth;
            resolution <= next_resolution;
            readData <= next_readData;
            analogCtrl <= next_analogCtrl;
        end
    end

    assign irq = irqFlag && irqEnable;

    // =====================================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !clockEnable);

    a_start_launches: assert property (startAccept |=> state == SEQ_SAMPLE && !eoc)
        else $error("accepted start did not launch sampling");
    a_disable_powers_off: assert property (!enable && !(writeMode && writeData[MODE_ENABLE_BIT])
        |=> state == SEQ_IDLE && !analogCtrl.powerUp)
        else $error("converter active while disabled");
    a_start_reads_zero: assert property (readStrobe && address == MODE_CONTROL_ADDR
        |=> readData[MODE_START_BIT] == 1'b0)
        else $error("start bit read back nonzero");
    a_busy_status_low: assert property (state != SEQ_IDLE |-> !eoc)
        else $error("done status high during conversion");
    a_done_sets_all: assert property (conversionDone |=> eoc && irqFlag && result == $past(decided))
        else $error("completion did not update status, flag and result");
    a_global_off: assert property (!globalSel |=> analogCtrl.channelConnect == '0)
        else $error("channel connected while globally disabled");
    a_channel_onehot: assert property (globalSel && channelSel <= 4'hC
        |=> $onehot(analogCtrl.channelConnect))
        else $error("selected channel not uniquely connected");
    a_flag_sticky: assert property (irqFlag && !(writeClock && writeData[CLOCK_FLAG_BIT]) |=> irqFlag)
        else $error("interrupt flag lost without firmware clear");
    a_irq_masked: assert property (!irqEnable |-> !irq)
        else $error("interrupt raised while masked");
    a_div_eight: assert property (tick && clockDiv == 2'h1 && !writeClock |=> !tick [*7])
        else $error("divide by eight tick spacing wrong");
    a_div_one: assert property (state != SEQ_IDLE && clockDiv == 2'h2 |-> tick)
        else $error("divide by one missed a tick");
    a_low_nibble_read: assert property (readStrobe && address == CLOCK_FLAG_ADDR
        |=> readData[3:0] == $past(result[3:0]))
        else $error("low result nibble read wrong");
    a_short_zero_fill: assert property (conversionDone && resolution == 2'h0 |=> result[3:0] == 4'h0)
        else $error("8-bit result not zero filled");
    a_flag_set_source: assert property (!irqFlag && !conversionDone |=> !irqFlag)
        else $error("interrupt flag set without a completion");
    a_done_idles: assert property (conversionDone |=> state == SEQ_IDLE)
        else $error("sequencer kept running after completion");
    a_busy_start_ignored: assert property (writeMode && state == SEQ_CONVERT |=> state != SEQ_SAMPLE)
        else $error("start during conversion relaunched sampling");
    a_high_byte_read: assert property (readStrobe && address == RESULT_HIGH_ADDR
        |=> readData == $past(result[11:4]))
        else $error("high result byte read wrong");
    a_sample_pulse: assert property (state == SEQ_SAMPLE |=> analogCtrl.sampling)
        else $error("sample pulse missing during sampling");
    a_ext_ref_follow: assert property (1'b1 |=> analogCtrl.externalReference == $past(extRef))
        else $error("reference source not passed to analog core");
    a_portb_off_follow: assert property (1'b1 |=> analogCtrl.portbDigitalOff == $past(analogOnly))
        else $error("analog-only bits not passed to pads");

    c_done_8bit: cover property (conversionDone && resolution == 2'h0);
    c_done_12bit: cover property (conversionDone && resolution[1]);
    c_irq_raised: cover property (!irq ##1 irq);
    c_abort: cover property (abortConversion);

endmodule : adc_control_regs
